// File: core/mpsc_pkg.sv
// Shared constants and types of the port status and control register bank
package mpsc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_TX_STAT = 8'h00;
    localparam logic [7:0] OFF_RX_STAT = 8'h04;
    localparam logic [7:0] OFF_PORT_CTRL = 8'h08;
    localparam logic [7:0] OFF_TX_ERR_CFG = 8'h0C;
    localparam logic [7:0] OFF_RX_FILT_CFG = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;
    // Transmit status fields
    localparam int unsigned TX_PKC_LSB = 6;
    localparam int unsigned TX_XCOL_BIT = 2;
    localparam int unsigned TX_LCOL_BIT = 1;
    localparam int unsigned TX_UNF_BIT = 0;
    // Receive status fields
    localparam int unsigned RX_PAUSE_BIT = 7;
    localparam int unsigned RX_LINE_BIT = 5;
    localparam int unsigned RX_LONG_BIT = 4;
    localparam int unsigned RX_RUNT_BIT = 3;
    localparam int unsigned RX_ALIGN_BIT = 2;
    localparam int unsigned RX_CRC_BIT = 1;
    localparam int unsigned RX_OVF_BIT = 0;
    // Port control fields
    localparam int unsigned PC_RESTART_BIT = 5;
    localparam int unsigned PC_TX_PATH_ENABLE_BIT = 4;
    localparam int unsigned PC_RX_PATH_ENABLE_BIT = 3;
    localparam int unsigned PC_DPRST_BIT = 2;
    localparam int unsigned PC_CFGRST_BIT = 1;
    localparam int unsigned PC_STCLR_BIT = 0;
    // Mode register field
    localparam int unsigned MODE_CODED_BIT = 0;
    // Reset values and receive filter write mask
    localparam logic [2:0] TX_ERR_RST = 3'h0;
    localparam logic [1:0] PKC_RST = 2'h0;
    localparam logic [7:0] RX_STAT_RST = 8'h00;
    localparam logic [2:0] TX_ERR_CFG_RST = 3'h0;
    localparam logic [7:0] RX_FILT_CFG_RST = 8'h00;
    localparam logic RX_FILT_MASK_BIT6 = 1'b0;
    localparam logic [7:0] RX_FILT_MASK = 8'hBF;
    localparam logic MODE_CODED_RST = 1'b0;
    localparam logic TX_EN_RST = 1'b0;
    localparam logic RX_EN_RST = 1'b0;
    // Counts
    localparam logic [1:0] PKC_MAX = 2'h2;
    localparam int unsigned TX_MAX_ATTEMPTS = 16;
    localparam int unsigned STATS_CLEAR_CYCLES = 100;

    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_STATUS} mpsc_rx_st_t;
endpackage : mpsc_pkg

// File: core/mpsc_bus_if.sv
// Internal register access carrier between bus slave and register core
`timescale 1ns/1ns
interface mpsc_bus_if #(parameter int ADR_W = 8);
    logic [ADR_W-1:0] adr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic wr;
    logic rd;
    modport slave (output adr, output wdat, output wr, output rd, input rdat);
    modport core (input adr, input wdat, input wr, input rd, output rdat);
endinterface : mpsc_bus_if

// File: core/mpsc_wb_slave.sv
// Classic Wishbone slave with one wait state, byte-wide registers
`timescale 1ns/1ns
module mpsc_wb_slave import mpsc_pkg::*; #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    mpsc_bus_if.slave bus
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } mpsc_wb_st_t;

    mpsc_wb_st_t q;
    mpsc_wb_st_t d;
    logic req;

    // Ack is withheld in the cycle after it is given, so each request acts once
    assign req = wb_cyc_i && wb_stb_i && !q.ack;
    assign bus.adr = wb_adr_i;
    assign bus.wdat = wb_dat_i[7:0];
    assign bus.wr = req && wb_we_i && wb_sel_i[0];
    assign bus.rd = req && !wb_we_i;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;

    always_comb begin
        d = q;
        d.ack = req;
        if (req) begin
            d.dat = wb_we_i ? 32'h0000_0000 : {24'h00_0000, bus.rdat};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{ack: 1'b0, dat: 32'h0000_0000};
        end else begin
            q <= d;
        end
    end
endmodule : mpsc_wb_slave

// File: core/mpsc_clr_timer.sv
// Holds the statistics clear strobe for a fixed number of cycles
`timescale 1ns/1ns
module mpsc_clr_timer import mpsc_pkg::*; #(
    parameter int CYCLES = STATS_CLEAR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
    } mpsc_clr_st_t;

    mpsc_clr_st_t q;
    mpsc_clr_st_t d;

    assign busy_o = q.busy;

    always_comb begin
        d = q;
        if (q.busy) begin
            d.cnt = q.cnt - 1'b1;
            d.busy = (q.cnt != CW'(1));
        end else if (start_i) begin
            d.busy = 1'b1;
            d.cnt = CW'(CYCLES);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{busy: 1'b0, cnt: '0};
        end else begin
            q <= d;
        end
    end
endmodule : mpsc_clr_timer

// File: core/mpsc_port_ctl.sv
// Per-port transmit status, receive status and port control register bank
// Operation
// - Transmit status read clears errors, keeps count
// - Transmit error set only if stop configured
// - Excessive collision after sixteen failed attempts
// - Late collision after sixty-four bytes sent
// - Underflow when FIFO empties past sixty-four bytes
// - Receive status read clears every bit
// - Receive bit set only if filter passes it
// - Partly allowed multiple errors set no bits
// - Status byte follows last data byte in FIFO
// - Bit 7 marks flow-control frame
// - Bit 5 marks symbol or MII error
// - Bits 4,3 mark oversize and runt frames
// - Bits 2,1 mark alignment and CRC errors
// - Bit 0 marks receive FIFO overflow
// - Control bit 5 restarts stopped transmitter
// - Bit 4 enables transmit, halts after packet
// - Bit 3 enables receive, halts after packet
// - Stop raised once all disabled paths halted
// - Bit 2 resets transmit and receive logic
// - Bit 1 restores registers except port control
// - Bit 0 clears statistics for 100 cycles
`timescale 1ns/1ns
module mpsc_port_ctl import mpsc_pkg::*; #(
    parameter int ADR_W = 8,
    parameter int CLEAR_CYCLES = STATS_CLEAR_CYCLES,
    parameter int MAX_ATTEMPTS = TX_MAX_ATTEMPTS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_pkt_load_i,
    input wire logic tx_pkt_sent_i,
    input wire logic tx_busy_i,
    input wire logic tx_collision_i,
    input wire logic tx_past_min_i,
    input wire logic tx_fifo_empty_i,
    output logic tx_go_o,
    output logic tx_stopped_o,
    output logic tx_restart_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    input wire logic rx_pause_i,
    input wire logic rx_sym_err_i,
    input wire logic rx_mii_er_i,
    input wire logic rx_too_long_i,
    input wire logic rx_too_short_i,
    input wire logic rx_crc_err_i,
    input wire logic rx_frame_err_i,
    input wire logic rx_fifo_full_i,
    output logic rx_ready_o,
    output logic rx_fifo_wr_o,
    output logic [7:0] rx_fifo_data_o,
    output logic port_stop_o,
    output logic datapath_rst_o,
    output logic stats_clear_o,
    output logic coded_line_mode_o
);
    localparam int CCW = $clog2(MAX_ATTEMPTS + 1);

    typedef struct packed {
        mpsc_rx_st_t rx_st;
        logic rx_wr;
        logic [7:0] rx_dat;
        logic [7:0] rx_app;
        logic rx_line;
        logic rx_ovf;
        logic [1:0] pending_packet_count;
        logic [CCW-1:0] coll_cnt;
        logic [2:0] tx_err;
        logic tx_stop;
        logic [7:0] rx_stat;
        logic tx_en;
        logic rx_en;
        logic [2:0] tx_cfg;
        logic [7:0] rx_cfg;
        logic coded;
        logic restart;
        logic dp_rst;
        logic stop;
    } mpsc_core_st_t;

    localparam mpsc_core_st_t CORE_RST = '{
        rx_st: RX_IDLE, rx_wr: 1'b0, rx_dat: 8'h00, rx_app: RX_STAT_RST,
        rx_line: 1'b0, rx_ovf: 1'b0, pending_packet_count: PKC_RST, coll_cnt: '0,
        tx_err: TX_ERR_RST, tx_stop: 1'b0, rx_stat: RX_STAT_RST,
        tx_en: TX_EN_RST, rx_en: RX_EN_RST, tx_cfg: TX_ERR_CFG_RST,
        rx_cfg: RX_FILT_CFG_RST, coded: MODE_CODED_RST, restart: 1'b0,
        dp_rst: 1'b0, stop: 1'b0};

    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
        hit = (adr == ADR_W'(off));
    endfunction : hit

    mpsc_core_st_t q;
    mpsc_core_st_t d;
    mpsc_bus_if #(.ADR_W(ADR_W)) bus ();

    logic clr_busy;
    logic wr_pc;
    logic cfg_rst;
    logic dp_rst;
    logic clr_go;
    logic rd_tx;
    logic rd_rx;
    logic coll_early;
    logic ev_xcol;
    logic ev_lcol;
    logic ev_unf;
    logic [2:0] tx_ev;
    logic pkc_inc;
    logic pkc_dec;
    logic rx_take;
    logic rx_in_frame;
    logic rx_line_now;
    logic rx_ovf_now;
    logic [7:0] rx_ev;
    logic [7:0] rx_pass;
    logic tx_halted;
    logic rx_halted;
    logic [7:0] rdat;

    mpsc_wb_slave #(.ADR_W(ADR_W)) u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(bus.slave)
    );

    mpsc_clr_timer #(.CYCLES(CLEAR_CYCLES)) u_clr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(clr_go),
        .busy_o(clr_busy)
    );

    assign wr_pc = bus.wr && hit(bus.adr, OFF_PORT_CTRL);
    assign cfg_rst = wr_pc && bus.wdat[PC_CFGRST_BIT];
    assign dp_rst = wr_pc && (bus.wdat[PC_DPRST_BIT] || cfg_rst);
    // clear request is not combined with config reset
    assign clr_go = wr_pc && bus.wdat[PC_STCLR_BIT] && !cfg_rst;
    assign rd_tx = bus.rd && hit(bus.adr, OFF_TX_STAT);
    assign rd_rx = bus.rd && hit(bus.adr, OFF_RX_STAT);

    assign ev_lcol = tx_collision_i && tx_past_min_i;
    assign coll_early = tx_collision_i && !tx_past_min_i;
    assign ev_xcol = coll_early && (q.coll_cnt == CCW'(MAX_ATTEMPTS - 1));
    assign ev_unf = tx_fifo_empty_i && tx_busy_i && tx_past_min_i;
    assign tx_ev = {ev_xcol, ev_lcol, ev_unf} & q.tx_cfg;

    assign pkc_inc = tx_pkt_load_i && (q.pending_packet_count != PKC_MAX);
    assign pkc_dec = tx_pkt_sent_i && (q.pending_packet_count != PKC_RST);

    assign rx_ready_o = (q.rx_st == RX_FRAME) || ((q.rx_st == RX_IDLE) && q.rx_en);
    assign rx_take = rx_valid_i && rx_ready_o;
    assign rx_in_frame = rx_take || (q.rx_st == RX_FRAME);
    assign rx_line_now = q.rx_line || (rx_in_frame && (q.coded ? rx_sym_err_i : rx_mii_er_i));
    assign rx_ovf_now = q.rx_ovf || (rx_take && rx_fifo_full_i);

    always_comb begin
        rx_ev = RX_STAT_RST;
        rx_ev[RX_PAUSE_BIT] = rx_pause_i;
        rx_ev[RX_LINE_BIT] = rx_line_now;
        rx_ev[RX_LONG_BIT] = rx_too_long_i;
        rx_ev[RX_RUNT_BIT] = rx_too_short_i;
        // CRC with and without framing error
        rx_ev[RX_ALIGN_BIT] = rx_crc_err_i && rx_frame_err_i;
        rx_ev[RX_CRC_BIT] = rx_crc_err_i && !rx_frame_err_i;
        rx_ev[RX_OVF_BIT] = rx_ovf_now;
    end

    // all events must be allowed, else none reported
    assign rx_pass = ((rx_ev & ~q.rx_cfg) == 8'h00) ? rx_ev : RX_STAT_RST;

    // transmit halts when idle after disable
    assign tx_halted = !q.tx_en && !tx_busy_i;
    assign rx_halted = !q.rx_en && (q.rx_st == RX_IDLE);

    always_comb begin
        rdat = 8'h00;
        if (hit(bus.adr, OFF_TX_STAT)) begin
            rdat = {q.pending_packet_count, 3'b000, q.tx_err};
        end else if (hit(bus.adr, OFF_RX_STAT)) begin
            rdat = q.rx_stat;
        end else if (hit(bus.adr, OFF_PORT_CTRL)) begin
            rdat = 8'h00;
            rdat[PC_TX_PATH_ENABLE_BIT] = q.tx_en;
            rdat[PC_RX_PATH_ENABLE_BIT] = q.rx_en;
            rdat[PC_STCLR_BIT] = clr_busy;
        end else if (hit(bus.adr, OFF_TX_ERR_CFG)) begin
            rdat = {5'b00000, q.tx_cfg};
        end else if (hit(bus.adr, OFF_RX_FILT_CFG)) begin
            rdat = q.rx_cfg;
        end else if (hit(bus.adr, OFF_MODE)) begin
            rdat = 8'h00;
            rdat[MODE_CODED_BIT] = q.coded;
        end
    end
    assign bus.rdat = rdat;

    always_comb begin
        d = q;
        d.restart = 1'b0;
        d.dp_rst = dp_rst;
        d.rx_wr = 1'b0;

        // Configuration writes
        if (bus.wr && hit(bus.adr, OFF_TX_ERR_CFG)) begin
            d.tx_cfg = bus.wdat[2:0];
        end
        if (bus.wr && hit(bus.adr, OFF_RX_FILT_CFG)) begin
            d.rx_cfg = bus.wdat & RX_FILT_MASK;
        end
        if (bus.wr && hit(bus.adr, OFF_MODE)) begin
            d.coded = bus.wdat[MODE_CODED_BIT];
        end
        if (wr_pc) begin
            d.tx_en = bus.wdat[PC_TX_PATH_ENABLE_BIT];
            d.rx_en = bus.wdat[PC_RX_PATH_ENABLE_BIT];
            if (bus.wdat[PC_RESTART_BIT]) begin
                d.restart = 1'b1;
                d.tx_stop = 1'b0;
            end
        end

        if (rd_tx) begin
            d.tx_err = TX_ERR_RST;
        end
        // set after clear, so a same-cycle event survives
        d.tx_err = d.tx_err | tx_ev;
        if (tx_ev != 3'b000) begin
            d.tx_stop = 1'b1;
        end

        if (tx_pkt_sent_i || ev_xcol || ev_lcol) begin
            d.coll_cnt = '0;
        end else if (coll_early) begin
            d.coll_cnt = q.coll_cnt + 1'b1;
        end

        if (pkc_inc && !pkc_dec) begin
            d.pending_packet_count = q.pending_packet_count + 1'b1;
        end else if (pkc_dec && !pkc_inc) begin
            d.pending_packet_count = q.pending_packet_count - 1'b1;
        end

        if (rd_rx) begin
            d.rx_stat = RX_STAT_RST;
        end

        case (q.rx_st)
            RX_IDLE, RX_FRAME: begin
                d.rx_line = rx_line_now;
                d.rx_ovf = rx_ovf_now;
                if (rx_take) begin
                    d.rx_wr = !rx_fifo_full_i;
                    d.rx_dat = rx_data_i;
                    d.rx_st = RX_FRAME;
                    if (rx_last_i) begin
                        d.rx_st = RX_STATUS;
                        d.rx_app = rx_pass;
                        d.rx_stat = d.rx_stat | rx_pass;
                    end
                end
            end
            RX_STATUS: begin
                // status byte after last data byte
                d.rx_wr = 1'b1;
                d.rx_dat = q.rx_app;
                d.rx_line = 1'b0;
                d.rx_ovf = 1'b0;
                d.rx_st = RX_IDLE;
            end
            default: begin
                d.rx_st = RX_IDLE;
            end
        endcase

        // stop only when every disabled path has halted
        d.stop = (!q.tx_en || !q.rx_en) && (q.tx_en || tx_halted) && (q.rx_en || rx_halted);

        if (dp_rst) begin
            d.rx_st = RX_IDLE;
            d.rx_wr = 1'b0;
            d.rx_line = 1'b0;
            d.rx_ovf = 1'b0;
            d.pending_packet_count = PKC_RST;
            d.coll_cnt = '0;
            d.tx_stop = 1'b0;
        end
        // registers other than port control to defaults
        if (cfg_rst) begin
            d.tx_err = TX_ERR_RST;
            d.rx_stat = RX_STAT_RST;
            d.tx_cfg = TX_ERR_CFG_RST;
            d.rx_cfg = RX_FILT_CFG_RST;
            d.coded = MODE_CODED_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    assign tx_go_o = q.tx_en && !q.tx_stop;
    assign tx_stopped_o = q.tx_stop;
    assign tx_restart_o = q.restart;
    assign rx_fifo_wr_o = q.rx_wr;
    assign rx_fifo_data_o = q.rx_dat;
    assign port_stop_o = q.stop;
    assign datapath_rst_o = q.dp_rst;
    assign stats_clear_o = clr_busy;
    assign coded_line_mode_o = q.coded;
endmodule : mpsc_port_ctl

// File: test/mpsc_port_ctl_properties.sv
// Concurrent checks on the port status and control register bank
`timescale 1ns/1ns
module mpsc_port_ctl_props import mpsc_pkg::*; #(
    parameter int ADR_W = 8,
    parameter int CLEAR_CYCLES = STATS_CLEAR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic tx_go_o,
    input wire logic tx_stopped_o,
    input wire logic tx_restart_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    input wire logic rx_fifo_full_i,
    input wire logic rx_ready_o,
    input wire logic rx_fifo_wr_o,
    input wire logic [7:0] rx_fifo_data_o,
    input wire logic datapath_rst_o,
    input wire logic stats_clear_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic pc_wr;
    logic rx_take;
    logic [15:0] clr_cnt_q;
    assign pc_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == ADR_W'(OFF_PORT_CTRL);
    assign rx_take = rx_valid_i && rx_ready_o && !rx_fifo_full_i;
    // Counts the cycles of the running statistics clear
    always_ff @(posedge clk_i) begin
        if (rst_i || !stats_clear_o) begin
            clr_cnt_q <= '0;
        end else begin
            clr_cnt_q <= clr_cnt_q + 16'h0001;
        end
    end
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack in the next cycle");
    a_rx_byte_copy: assert property (rx_take |=> rx_fifo_wr_o && rx_fifo_data_o == $past(rx_data_i))
        else $error("byte not copied to fifo");
    a_rx_status_slot: assert property (rx_valid_i && rx_ready_o && rx_last_i |=> !rx_ready_o ##1 rx_fifo_wr_o)
        else $error("no status byte slot");
    a_restart_pulse: assert property (pc_wr && wb_dat_i[PC_RESTART_BIT] |-> ##[1:2] tx_restart_o)
        else $error("no restart pulse");
    a_restart_single: assert property (tx_restart_o |=> !tx_restart_o)
        else $error("restart pulse too long");
    a_stopped_no_go: assert property (tx_stopped_o ##1 tx_stopped_o |-> !tx_go_o)
        else $error("go while stopped");
    a_dprst_pulse: assert property (pc_wr && (wb_dat_i[PC_DPRST_BIT] || wb_dat_i[PC_CFGRST_BIT]) |-> ##[1:3] datapath_rst_o)
        else $error("no datapath reset");
    a_dprst_single: assert property (datapath_rst_o |=> !datapath_rst_o)
        else $error("datapath reset too long");
    a_clear_start: assert property (pc_wr && wb_dat_i[0] && !wb_dat_i[1] && !stats_clear_o |-> ##[1:2] stats_clear_o)
        else $error("clear did not start");
    a_clear_length: assert property ($fell(stats_clear_o) && !$past(rst_i) |-> clr_cnt_q == CLEAR_CYCLES)
        else $error("clear length wrong");
    c_rx_frame: cover property (rx_valid_i && rx_ready_o && rx_last_i);
    c_restart: cover property (tx_restart_o);
    c_clear_end: cover property ($fell(stats_clear_o));
endmodule : mpsc_port_ctl_props

// File: test/tb_mpsc_port_ctl.sv
// Self-checking bench for the port status and control register bank
`timescale 1ns/1ns
module tb_mpsc_port_ctl import mpsc_pkg::*;;
    localparam int CLR = 5;
    logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
    logic [7:0] wb_adr_i = '0, rx_data_i = '0, rx_fifo_data_o;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rdata;
    logic [2:0] tx_pls = '0;
    logic wb_ack_o, tx_go_o, tx_stopped_o, tx_restart_o, rx_ready_o, rx_fifo_wr_o;
    logic port_stop_o, datapath_rst_o, stats_clear_o, coded_line_mode_o;
    logic tx_busy_i = '0, tx_past_min_i = '0, tx_fifo_empty_i = '0, rx_valid_i = '0, rx_last_i = '0;
    logic rx_pause_i = '0, rx_sym_err_i = '0, rx_mii_er_i = '0, rx_too_long_i = '0, rx_too_short_i = '0;
    logic rx_crc_err_i = '0, rx_frame_err_i = '0, rx_fifo_full_i = '0;
    int errors = 0, n_checks = 0, n_dprst = 0;
    logic [7:0] fifo_q[$];

    mpsc_port_ctl #(.CLEAR_CYCLES(CLR), .MAX_ATTEMPTS(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_pkt_load_i(tx_pls[0]), .tx_pkt_sent_i(tx_pls[1]), .tx_busy_i(tx_busy_i), .tx_collision_i(tx_pls[2]),
        .tx_past_min_i(tx_past_min_i), .tx_fifo_empty_i(tx_fifo_empty_i), .tx_go_o(tx_go_o),
        .tx_stopped_o(tx_stopped_o), .tx_restart_o(tx_restart_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .rx_last_i(rx_last_i), .rx_pause_i(rx_pause_i), .rx_sym_err_i(rx_sym_err_i), .rx_mii_er_i(rx_mii_er_i),
        .rx_too_long_i(rx_too_long_i), .rx_too_short_i(rx_too_short_i), .rx_crc_err_i(rx_crc_err_i),
        .rx_frame_err_i(rx_frame_err_i), .rx_fifo_full_i(rx_fifo_full_i), .rx_ready_o(rx_ready_o),
        .rx_fifo_wr_o(rx_fifo_wr_o), .rx_fifo_data_o(rx_fifo_data_o), .port_stop_o(port_stop_o),
        .datapath_rst_o(datapath_rst_o), .stats_clear_o(stats_clear_o), .coded_line_mode_o(coded_line_mode_o)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (rx_fifo_wr_o === 1'b1) fifo_q.push_back(rx_fifo_data_o);
        if (datapath_rst_o === 1'b1) n_dprst++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Classic single cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h00_0000, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        check(wb_ack_o, 1'b1, "bus answer");
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wb_wr(input logic [7:0] adr, input logic [7:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask : wb_wr

    task automatic wb_rd(input logic [7:0] adr, input logic [7:0] exp, input string what);
        wb_xfer(1'b0, adr, 8'h00);
        check(rdata, {24'h00_0000, exp}, what);
    endtask : wb_rd

    task automatic tx_pulse(input logic [2:0] which, input int n);
        repeat (n) begin
            @(posedge clk_i);
            tx_pls <= which;
            @(posedge clk_i);
            tx_pls <= '0;
        end
    endtask : tx_pulse

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // Two-byte frame carrying the events in ev, laid out as the status bits
    task automatic rx_frame(input logic [7:0] ev, input logic coded_line_mode, input logic [7:0] exp);
        int n;
        fifo_q.delete();
        {rx_pause_i, rx_mii_er_i, rx_too_long_i, rx_too_short_i} <= {ev[7], ev[5], ev[4], ev[3]};
        {rx_sym_err_i, rx_crc_err_i, rx_frame_err_i} <= {coded_line_mode, ev[2] | ev[1], ev[2]};
        for (int i = 0; i < 2; i++) begin
            rx_valid_i <= 1'b1;
            rx_data_i <= 8'hA0 + 8'(i);
            rx_last_i <= (i == 1);
            rx_fifo_full_i <= ev[0] && (i == 0);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (rx_ready_o !== 1'b1 && n < 20);
        end
        {rx_valid_i, rx_last_i, rx_pause_i, rx_mii_er_i, rx_too_long_i, rx_too_short_i} <= '0;
        {rx_sym_err_i, rx_crc_err_i, rx_frame_err_i} <= '0;
        wait_clk(3);
        check(fifo_q.size(), ev[0] ? 2 : 3, "fifo byte count");
        check(fifo_q[fifo_q.size() - 2], 8'hA1, "last data byte");
        check(fifo_q[$], exp, "appended status");
        wb_rd(OFF_RX_STAT, exp, "rx status");
        wb_rd(OFF_RX_STAT, 8'h00, "rx status after read");
    endtask : rx_frame

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        wait_clk(20000);
        errors++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        wait_clk(16);
        rst_i <= 1'b0;
        wb_rd(OFF_TX_STAT, 8'h00, "tx status reset");
        wb_rd(OFF_RX_STAT, 8'h00, "rx status reset");
        wb_rd(OFF_PORT_CTRL, 8'h00, "control reset value");
        wb_rd(8'h40, 8'h00, "unmapped read");
        $display("test reset values done");
        tx_pulse(3'b001, 3);
        wb_rd(OFF_TX_STAT, 8'h80, "count saturates");
        tx_pulse(3'b010, 1);
        wb_rd(OFF_TX_STAT, 8'h40, "count after send");
        tx_pulse(3'b010, 1);
        $display("test packet count done");
        {tx_busy_i, tx_past_min_i} <= 2'b11;
        tx_pulse(3'b100, 1);
        wb_rd(OFF_TX_STAT, 8'h00, "error without stop config");
        wb_wr(OFF_TX_ERR_CFG, 8'h07);
        wb_wr(OFF_PORT_CTRL, 8'h18);
        tx_pulse(3'b100, 1);
        wait_clk(2);
        check({tx_stopped_o, tx_go_o}, 2'b10, "stopped on late collision");
        wb_rd(OFF_TX_STAT, 8'h02, "late collision");
        fork
            wb_rd(OFF_TX_STAT, 8'h00, "errors cleared by read");
            tx_pulse(3'b100, 1);
        join
        wb_rd(OFF_TX_STAT, 8'h02, "event survives read");
        wb_wr(OFF_PORT_CTRL, 8'h38);
        wait_clk(2);
        check({tx_stopped_o, tx_go_o}, 2'b01, "restarted");
        tx_fifo_empty_i <= 1'b1;
        wait_clk(2);
        tx_fifo_empty_i <= 1'b0;
        wb_rd(OFF_TX_STAT, 8'h01, "underflow");
        wb_wr(OFF_PORT_CTRL, 8'h38);
        tx_past_min_i <= 1'b0;
        tx_pulse(3'b100, 3);
        wb_rd(OFF_TX_STAT, 8'h00, "one attempt short");
        tx_pulse(3'b100, 1);
        wb_rd(OFF_TX_STAT, 8'h04, "excessive collisions");
        wb_wr(OFF_PORT_CTRL, 8'h38);
        tx_busy_i <= 1'b0;
        wb_rd(OFF_PORT_CTRL, 8'h18, "control readback");
        $display("test transmit errors done");
        wb_wr(OFF_RX_FILT_CFG, 8'hBF);
        for (int b = 0; b < 8; b++) if (b != 6) rx_frame(8'h01 << b, 1'b0, 8'h01 << b);
        wb_wr(OFF_RX_FILT_CFG, 8'h02);
        rx_frame(8'h0A, 1'b0, 8'h00);
        wb_wr(OFF_RX_FILT_CFG, 8'h0A);
        rx_frame(8'h0A, 1'b0, 8'h0A);
        wb_wr(OFF_RX_FILT_CFG, 8'h00);
        rx_frame(8'h02, 1'b0, 8'h00);
        wb_wr(OFF_MODE, 8'h01);
        wb_wr(OFF_RX_FILT_CFG, 8'hBF);
        check(coded_line_mode_o, 1'b1, "coded mode output");
        rx_frame(8'h00, 1'b1, 8'h20);
        $display("test receive status done");
        tx_busy_i <= 1'b1;
        wb_wr(OFF_PORT_CTRL, 8'h00);
        wait_clk(3);
        check(port_stop_o, 1'b0, "stop before tx halted");
        tx_busy_i <= 1'b0;
        wait_clk(3);
        check(port_stop_o, 1'b1, "stop after both halted");
        wb_wr(OFF_PORT_CTRL, 8'h04);
        wait_clk(4);
        check(n_dprst, 1, "port reset pulse");
        wb_wr(OFF_PORT_CTRL, 8'h01);
        wait_clk(CLR + 4);
        wb_rd(OFF_PORT_CTRL, 8'h00, "clear finished");
        $display("test port control done");
        wb_wr(OFF_TX_ERR_CFG, 8'h05);
        tx_pulse(3'b001, 1);
        wb_wr(OFF_PORT_CTRL, 8'h1A);
        wait_clk(4);
        check(n_dprst, 2, "control reset pulse");
        wb_rd(OFF_TX_ERR_CFG, 8'h00, "config restored");
        wb_rd(OFF_TX_STAT, 8'h00, "count restored");
        wb_rd(OFF_MODE, 8'h00, "mode restored");
        wb_rd(OFF_PORT_CTRL, 8'h18, "control kept");
        $display("test control reset done");
        summarize();
    end
endmodule : tb_mpsc_port_ctl

bind mpsc_port_ctl mpsc_port_ctl_props #(.ADR_W(ADR_W), .CLEAR_CYCLES(CLEAR_CYCLES)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .tx_go_o(tx_go_o),
    .tx_stopped_o(tx_stopped_o), .tx_restart_o(tx_restart_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_last_i(rx_last_i), .rx_fifo_full_i(rx_fifo_full_i), .rx_ready_o(rx_ready_o), .rx_fifo_wr_o(rx_fifo_wr_o),
    .rx_fifo_data_o(rx_fifo_data_o), .datapath_rst_o(datapath_rst_o), .stats_clear_o(stats_clear_o)
);
